/* abgo_bank.sv */
// Purpose: A/B path gain and offset configuration bank
// Assumes: Wishbone classic, one clock, synchronous reset
// Notes: adaption and compensation values come from outside logic
`timescale 1ns/1ps
`default_nettype none
module abgo_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] input_float_i,
  input wire logic temp_comp_en_i,
  input wire logic [1:0] temp_comp_valid_i,
  input wire abgo_pkg::abgo_fine_t temp_fine_a_i,
  input wire abgo_pkg::abgo_fine_t temp_fine_b_i,
  input wire logic adapt_en_i,
  input wire logic [1:0] adapt_wr_i,
  input wire abgo_pkg::abgo_fine_t adapt_a_i,
  input wire abgo_pkg::abgo_fine_t adapt_b_i,
  output logic ab_single_ended_sel_o,
  output logic ab_fault_sense_en_o,
  output logic sensor_error_o,
  output abgo_pkg::abgo_path_t path_a_o,
  output abgo_pkg::abgo_path_t path_b_o
);
  import abgo_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [3:0] float_s;
  abgo_sync #(
    .W(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(input_float_i),
    .q_o(float_s)
  );

  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic en);
    lane_merge = en ? new_v : old_v;
  endfunction

  // One strobe per mapped register index
  typedef struct packed {
    logic config1;
    logic config3;
    logic coarse_gain;
    logic stat_ofs_a;
    logic stat_ofs_b;
    logic trim_gain_a;
    logic trim_gain_b;
    logic trim_ofs_a;
    logic trim_ofs_b;
    logic status;
  } abgo_hit_t;

  // One decoder for both directions keeps the map in a single place
  function automatic abgo_hit_t decode_idx(input logic [5:0] i);
    abgo_hit_t h;
    h = '0;
    if (i == IDX_CONFIG1) begin
      h.config1 = 1'b1;
    end else if (i == IDX_CONFIG3) begin
      h.config3 = 1'b1;
    end else if (i == IDX_COARSE_GAIN) begin
      h.coarse_gain = 1'b1;
    end else if (i == IDX_STATIC_OFS_A) begin
      h.stat_ofs_a = 1'b1;
    end else if (i == IDX_STATIC_OFS_B) begin
      h.stat_ofs_b = 1'b1;
    end else if (i == IDX_TRIM_GAIN_A) begin
      h.trim_gain_a = 1'b1;
    end else if (i == IDX_TRIM_GAIN_B) begin
      h.trim_gain_b = 1'b1;
    end else if (i == IDX_TRIM_OFS_A) begin
      h.trim_ofs_a = 1'b1;
    end else if (i == IDX_TRIM_OFS_B) begin
      h.trim_ofs_b = 1'b1;
    end else if (i == IDX_STATUS) begin
      h.status = 1'b1;
    end
    return h;
  endfunction

  // Compensation results are held until a fresh one arrives
  function automatic abgo_fine_t fine_pick(input logic comp_en,
                                           input logic comp_valid,
                                           input abgo_fine_t comp_v,
                                           input abgo_fine_t held_v,
                                           input logic [7:0] trim_gain,
                                           input logic [7:0] trim_ofs);
    abgo_fine_t f;
    f.gain = trim_gain;
    f.offset = trim_ofs;
    if (comp_en) begin
      f = comp_valid ? comp_v : held_v;
    end
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic ab_single_ended_sel_q, ab_single_ended_sel_d;
  logic ab_fault_sense_en_q, ab_fault_sense_en_d;
  logic [2:0] path_a_static_gain_q, path_a_static_gain_d;
  logic [2:0] path_b_static_gain_q, path_b_static_gain_d;
  logic [7:0] path_a_static_offset_q, path_a_static_offset_d;
  logic [7:0] path_b_static_offset_q, path_b_static_offset_d;
  logic [7:0] path_a_trim_gain_q, path_a_trim_gain_d;
  logic [7:0] path_b_trim_gain_q, path_b_trim_gain_d;
  logic [7:0] path_a_trim_offset_q, path_a_trim_offset_d;
  logic [7:0] path_b_trim_offset_q, path_b_trim_offset_d;
  logic sensor_error_q, sensor_error_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  abgo_path_t path_a_q, path_a_d;
  abgo_path_t path_b_q, path_b_d;
  logic [5:0] idx;
  logic req, wr;
  logic [7:0] wb0;
  logic [7:0] cfg1_v, cfg3_v, cgain_v;
  abgo_hit_t hit;
  abgo_hit_t wsel;

  assign idx = wb_adr_i[7:2];
  // Single cycle answer; ack drops the cycle after
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wb0 = wb_dat_i[7:0];
  assign hit = decode_idx(idx);
  // Write strobes only; a read never disturbs state
  assign wsel = wr ? hit : '0;

  always_comb begin
    cfg1_v = 8'h00;
    cfg1_v[SINGLE_ENDED_BIT] = ab_single_ended_sel_q;
    cfg3_v = 8'h00;
    cfg3_v[FAULT_SENSE_BIT] = ab_fault_sense_en_q;
    cgain_v = {2'h0, path_b_static_gain_q, path_a_static_gain_q};
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ab_single_ended_sel_d = ab_single_ended_sel_q;
    ab_fault_sense_en_d = ab_fault_sense_en_q;
    path_a_static_gain_d = path_a_static_gain_q;
    path_b_static_gain_d = path_b_static_gain_q;
    path_a_static_offset_d = path_a_static_offset_q;
    path_b_static_offset_d = path_b_static_offset_q;
    path_a_trim_gain_d = path_a_trim_gain_q;
    path_b_trim_gain_d = path_b_trim_gain_q;
    path_a_trim_offset_d = path_a_trim_offset_q;
    path_b_trim_offset_d = path_b_trim_offset_q;
    // Static fields only ever take bus writes
    if (wsel.config1) begin
      ab_single_ended_sel_d = wb0[SINGLE_ENDED_BIT];
    end else if (wsel.config3) begin
      ab_fault_sense_en_d = wb0[FAULT_SENSE_BIT];
    end else if (wsel.coarse_gain) begin
      path_a_static_gain_d = wb0[GAIN_A_LSB +: 3];
      path_b_static_gain_d = wb0[GAIN_B_LSB +: 3];
    end else if (wsel.stat_ofs_a) begin
      path_a_static_offset_d = wb0;
    end else if (wsel.stat_ofs_b) begin
      path_b_static_offset_d = wb0;
    end
    // Software writes hold; an adapt_wr_i strobe with adaption enabled wins over them
    if (adapt_en_i && adapt_wr_i[0]) begin
      path_a_trim_gain_d = adapt_a_i.gain;
      path_a_trim_offset_d = adapt_a_i.offset;
    end else begin
      path_a_trim_gain_d = lane_merge(path_a_trim_gain_q, wb0,
                                      wsel.trim_gain_a);
      path_a_trim_offset_d = lane_merge(path_a_trim_offset_q, wb0,
                                        wsel.trim_ofs_a);
    end
    if (adapt_en_i && adapt_wr_i[1]) begin
      path_b_trim_gain_d = adapt_b_i.gain;
      path_b_trim_offset_d = adapt_b_i.offset;
    end else begin
      path_b_trim_gain_d = lane_merge(path_b_trim_gain_q, wb0,
                                      wsel.trim_gain_b);
      path_b_trim_offset_d = lane_merge(path_b_trim_offset_q, wb0,
                                        wsel.trim_ofs_b);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ab_single_ended_sel_q <= 1'b0;
      ab_fault_sense_en_q <= 1'b0;
      path_a_static_gain_q <= RESET_GAIN;
      path_b_static_gain_q <= RESET_GAIN;
      path_a_static_offset_q <= RESET_BYTE;
      path_b_static_offset_q <= RESET_BYTE;
      path_a_trim_gain_q <= RESET_BYTE;
      path_b_trim_gain_q <= RESET_BYTE;
      path_a_trim_offset_q <= RESET_BYTE;
      path_b_trim_offset_q <= RESET_BYTE;
    end else begin
      ab_single_ended_sel_q <= ab_single_ended_sel_d;
      ab_fault_sense_en_q <= ab_fault_sense_en_d;
      path_a_static_gain_q <= path_a_static_gain_d;
      path_b_static_gain_q <= path_b_static_gain_d;
      path_a_static_offset_q <= path_a_static_offset_d;
      path_b_static_offset_q <= path_b_static_offset_d;
      path_a_trim_gain_q <= path_a_trim_gain_d;
      path_b_trim_gain_q <= path_b_trim_gain_d;
      path_a_trim_offset_q <= path_a_trim_offset_d;
      path_b_trim_offset_q <= path_b_trim_offset_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    // Level, not sticky: follows the pins while sensing is on
    sensor_error_d = ab_fault_sense_en_q && (|float_s);
    // Coarse fields pass through untouched by any compensation
    path_a_d.static_gain = path_a_static_gain_q;
    path_b_d.static_gain = path_b_static_gain_q;
    path_a_d.static_offset = path_a_static_offset_q;
    path_b_d.static_offset = path_b_static_offset_q;
    // Fine values follow trim registers unless compensation is on
    path_a_d.fine = fine_pick(temp_comp_en_i, temp_comp_valid_i[0],
                              temp_fine_a_i, path_a_q.fine,
                              path_a_trim_gain_q,
                              path_a_trim_offset_q);
    path_b_d.fine = fine_pick(temp_comp_en_i, temp_comp_valid_i[1],
                              temp_fine_b_i, path_b_q.fine,
                              path_b_trim_gain_q,
                              path_b_trim_offset_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sensor_error_q <= 1'b0;
      path_a_q <= '0;
      path_b_q <= '0;
    end else begin
      sensor_error_q <= sensor_error_d;
      path_a_q <= path_a_d;
      path_b_q <= path_b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ack_d = req;
    rdata_d = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (hit.config1) begin
        rdata_d[7:0] = cfg1_v;
      end else if (hit.config3) begin
        rdata_d[7:0] = cfg3_v;
      end else if (hit.coarse_gain) begin
        rdata_d[7:0] = cgain_v;
      end else if (hit.stat_ofs_a) begin
        rdata_d[7:0] = path_a_static_offset_q;
      end else if (hit.stat_ofs_b) begin
        rdata_d[7:0] = path_b_static_offset_q;
      end else if (hit.trim_gain_a) begin
        rdata_d[7:0] = path_a_trim_gain_q;
      end else if (hit.trim_gain_b) begin
        rdata_d[7:0] = path_b_trim_gain_q;
      end else if (hit.trim_ofs_a) begin
        rdata_d[7:0] = path_a_trim_offset_q;
      end else if (hit.trim_ofs_b) begin
        rdata_d[7:0] = path_b_trim_offset_q;
      end else if (hit.status) begin
        // Read only; a write to it is dropped
        rdata_d[0] = sensor_error_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign ab_single_ended_sel_o = ab_single_ended_sel_q;
  assign ab_fault_sense_en_o = ab_fault_sense_en_q;
  assign sensor_error_o = sensor_error_q;
  assign path_a_o = path_a_q;
  assign path_b_o = path_b_q;
endmodule
`default_nettype wire

/* abgo_pkg.sv */
// Purpose: constants and types for the A/B path gain and offset bank
// Assumes: classic Wishbone slave, 32-bit data, byte addressed words
// Notes: printed offsets are register indices; byte address is index*4
//
// What this block does
// - Config 0x01 bit 5 selects single ended inputs for A and B, reset 0.
// - Config 0x03 bit 0 enables pull-ups and fault reporting, reset 0.
// - With sensing on, any floating A or B input raises the sensor error.
// - Each path has a three bit coarse gain, code times 6 dB, reset 0.
// - Coarse gain is never changed by temperature or automatic compensation.
// - Coarse offsets A and B at 0x08 and 0x09, signed byte, reset 0.
// - Coarse offset code is steps of 40 mV, low five bits carry value.
// - Dynamic gain bytes at 0x0A and 0x0B, unsigned, reset 0.
// - Dynamic offset bytes at 0x0C and 0x0D, signed 2 mV, reset 0.
// - Compensation off: fine values come straight from the dynamic registers.
// - Compensation on: fine values come from the compensation logic.
// - Dynamic registers hold software value unless adaption overwrites them.
package abgo_pkg;
  localparam logic [5:0] IDX_CONFIG1 = 6'h01;
  localparam logic [5:0] IDX_CONFIG3 = 6'h03;
  localparam logic [5:0] IDX_COARSE_GAIN = 6'h07;
  localparam logic [5:0] IDX_STATIC_OFS_A = 6'h08;
  localparam logic [5:0] IDX_STATIC_OFS_B = 6'h09;
  localparam logic [5:0] IDX_TRIM_GAIN_A = 6'h0A;
  localparam logic [5:0] IDX_TRIM_GAIN_B = 6'h0B;
  localparam logic [5:0] IDX_TRIM_OFS_A = 6'h0C;
  localparam logic [5:0] IDX_TRIM_OFS_B = 6'h0D;
  localparam logic [5:0] IDX_STATUS = 6'h10;
  localparam int SINGLE_ENDED_BIT = 5;
  localparam int FAULT_SENSE_BIT = 0;
  localparam int GAIN_A_LSB = 0;
  localparam int GAIN_B_LSB = 3;
  localparam int MAX_STATIC_GAIN = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_GAIN = 3'h0;
  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] offset;
  } abgo_fine_t;
  typedef struct packed {
    logic [2:0] static_gain;
    logic [7:0] static_offset;
    abgo_fine_t fine;
  } abgo_path_t;
endpackage

/* abgo_sync.sv */
// Purpose: two flop synchroniser for a bus of pin levels
// Assumes: levels change slowly compared to clk_i
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module abgo_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule
`default_nettype wire

/* abgo_bank_sva.sv */
// Purpose: port-level checker for the A/B gain and offset bank
// Assumes: one clock, synchronous active high reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module abgo_bank_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] input_float_i,
  input wire logic temp_comp_en_i,
  input wire logic [1:0] temp_comp_valid_i,
  input wire abgo_pkg::abgo_fine_t temp_fine_a_i,
  input wire logic [1:0] adapt_wr_i,
  input wire logic ab_single_ended_sel_o,
  input wire logic ab_fault_sense_en_o,
  input wire logic sensor_error_o,
  input wire abgo_pkg::abgo_path_t path_a_o,
  input wire abgo_pkg::abgo_path_t path_b_o
);
  import abgo_pkg::*;
  logic wr;
  logic [5:0] idx;
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[7:2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=>
    wb_ack_o) else $error("request not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  mode_write_a: assert property (
    $changed(ab_single_ended_sel_o) |-> wr && idx == IDX_CONFIG1)
    else $error("input mode changed without a write");
  sense_write_a: assert property (
    $changed(ab_fault_sense_en_o) |-> wr && idx == IDX_CONFIG3)
    else $error("fault sense enable changed without a write");
  gain_hold_a: assert property (
    $changed({path_a_o.static_gain, path_b_o.static_gain}) |->
    $past(wr && idx == IDX_COARSE_GAIN))
    else $error("coarse gain moved without a write");
  trim_fine_a: assert property (
    (wr && idx == IDX_TRIM_GAIN_A && !temp_comp_en_i && !$past(adapt_wr_i[0]))
    |=> temp_comp_en_i || path_a_o.fine.gain == $past(wb_dat_i[7:0]))
    else $error("fine gain A does not follow trim register");
  comp_fine_a: assert property (
    (temp_comp_en_i && temp_comp_valid_i[0]) ##1
    (temp_comp_en_i && !temp_comp_valid_i[0])
    |=> path_a_o.fine == $past(temp_fine_a_i, 2))
    else $error("fine A does not follow compensation");
  err_set_a: assert property (
    (ab_fault_sense_en_o && |input_float_i)[*5] |-> sensor_error_o)
    else $error("floating input not reported");
  err_clear_a: assert property (
    (!ab_fault_sense_en_o)[*3] |-> !sensor_error_o)
    else $error("sensor error while sensing off");
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the A/B gain and offset bank
// Assumes: Wishbone classic master, ack answers in a few cycles
// Notes: random data from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import abgo_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF, input_float_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, v, rng = 32'h8;
  logic wb_ack_o, temp_comp_en_i = 1'b0, adapt_en_i = 1'b0;
  logic [1:0] temp_comp_valid_i = 2'h0, adapt_wr_i = 2'h0;
  abgo_fine_t temp_fine_a_i = 16'h0, temp_fine_b_i = 16'h0;
  abgo_fine_t adapt_a_i = 16'h0, adapt_b_i = 16'h0;
  logic ab_single_ended_sel_o, ab_fault_sense_en_o, sensor_error_o;
  abgo_path_t path_a_o, path_b_o;
  logic [2:0] ga, gb;
  logic [3:0] sel_v = 4'hF;
  logic [7:0] so;
  int fail_count = 0, tests_run = 0;
  logic [5:0] regs [9] = '{IDX_CONFIG1, IDX_CONFIG3, IDX_COARSE_GAIN,
    IDX_STATIC_OFS_A, IDX_STATIC_OFS_B, IDX_TRIM_GAIN_A, IDX_TRIM_GAIN_B,
    IDX_TRIM_OFS_A, IDX_TRIM_OFS_B};
  abgo_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .input_float_i(input_float_i),
    .temp_comp_en_i(temp_comp_en_i), .temp_comp_valid_i(temp_comp_valid_i),
    .temp_fine_a_i(temp_fine_a_i), .temp_fine_b_i(temp_fine_b_i),
    .adapt_en_i(adapt_en_i), .adapt_wr_i(adapt_wr_i), .adapt_a_i(adapt_a_i),
    .adapt_b_i(adapt_b_i), .ab_single_ended_sel_o(ab_single_ended_sel_o),
    .ab_fault_sense_en_o(ab_fault_sense_en_o),
    .sensor_error_o(sensor_error_o), .path_a_o(path_a_o), .path_b_o(path_b_o));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [2:0] legal_gain(input logic [2:0] c);
    return (c > 3'(MAX_STATIC_GAIN)) ? 3'(MAX_STATIC_GAIN) : c;
  endfunction
  function automatic logic [7:0] cgain_exp(input logic [2:0] a, b);
    return {2'b00, b, a};
  endfunction
  task automatic rnd;
    rng = xorshift(rng);
    v = rng;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Holds the request until ack is sampled, then releases for a cycle
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= sel_v;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check($sformatf("reg %h", idx), q, {24'h0, exp});
  endtask
  task automatic settle;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    for (int i = 0; i < 16; i++) begin
      rnd;
      ga = legal_gain(v[2:0]);
      gb = legal_gain(v[6:4]);
      so = {{3{v[12]}}, v[12:8]};
      bus(1'b1, IDX_COARSE_GAIN, cgain_exp(ga, gb));
      bus(1'b1, IDX_STATIC_OFS_A, so);
      bus(1'b1, IDX_TRIM_GAIN_A, v[23:16]);
      bus(1'b1, IDX_TRIM_OFS_B, v[31:24]);
      settle;
      check("gain a", path_a_o.static_gain, ga);
      check("gain b", path_b_o.static_gain, gb);
      check("ofs a", path_a_o.static_offset, so);
      check("fine gain a", path_a_o.fine.gain, v[23:16]);
      check("fine ofs b", path_b_o.fine.offset, v[31:24]);
      rd(IDX_STATIC_OFS_A, so);
      rd(IDX_TRIM_OFS_B, v[31:24]);
      rd(IDX_COARSE_GAIN, cgain_exp(ga, gb));
    end
    bus(1'b1, IDX_STATIC_OFS_B, 8'hE1);
    rd(IDX_STATIC_OFS_B, 8'hE1);
    bus(1'b1, IDX_STATIC_OFS_B, 8'h1F);
    rd(IDX_STATIC_OFS_B, 8'h1F);
    settle;
    check("ofs b", path_b_o.static_offset, 8'h1F);
    bus(1'b1, IDX_TRIM_GAIN_B, 8'hFF);
    rd(IDX_TRIM_GAIN_B, 8'hFF);
    bus(1'b1, IDX_TRIM_OFS_A, 8'h81);
    rd(IDX_TRIM_OFS_A, 8'h81);
    bus(1'b1, 6'h3F, 8'hA5);
    rd(6'h3F, 8'h00);
    sel_v = 4'hE;
    bus(1'b1, IDX_TRIM_GAIN_A, 8'h5A);
    sel_v = 4'hF;
    rd(IDX_TRIM_GAIN_A, v[23:16]);
    bus(1'b1, IDX_CONFIG1, 8'h20);
    bus(1'b1, IDX_CONFIG3, 8'h01);
    input_float_i <= 4'h4;
    settle;
    check("single ended", ab_single_ended_sel_o, 1'b1);
    check("sense en", ab_fault_sense_en_o, 1'b1);
    check("sensor error", sensor_error_o, 1'b1);
    rd(IDX_STATUS, 8'h01);
    bus(1'b1, IDX_CONFIG3, 8'h00);
    settle;
    check("error cleared", sensor_error_o, 1'b0);
    rnd;
    @(posedge clk_i);
    temp_comp_en_i <= 1'b1;
    temp_fine_a_i <= v[15:0];
    temp_fine_b_i <= v[31:16];
    temp_comp_valid_i <= 2'b11;
    @(posedge clk_i);
    temp_comp_valid_i <= 2'b00;
    settle;
    check("comp a", path_a_o.fine, v[15:0]);
    check("comp b", path_b_o.fine, v[31:16]);
    check("gain a kept", path_a_o.static_gain, ga);
    @(posedge clk_i);
    temp_comp_en_i <= 1'b0;
    adapt_en_i <= 1'b1;
    adapt_b_i <= v[15:0];
    adapt_wr_i <= 2'b10;
    @(posedge clk_i);
    adapt_wr_i <= 2'b00;
    rd(IDX_TRIM_GAIN_B, v[15:8]);
    rd(IDX_TRIM_OFS_B, v[7:0]);
    settle;
    check("fine after comp", path_b_o.fine, v[15:0]);
    give_verdict;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict;
  end
endmodule
bind abgo_bank abgo_bank_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .input_float_i(input_float_i),
  .temp_comp_en_i(temp_comp_en_i), .temp_comp_valid_i(temp_comp_valid_i),
  .temp_fine_a_i(temp_fine_a_i), .adapt_wr_i(adapt_wr_i),
  .ab_single_ended_sel_o(ab_single_ended_sel_o),
  .ab_fault_sense_en_o(ab_fault_sense_en_o),
  .sensor_error_o(sensor_error_o), .path_a_o(path_a_o), .path_b_o(path_b_o));
`default_nettype wire
